/* File: pcrc_clk_switch.sv */
// glitch-free system clock source switch with power-of-two prescaler
`timescale 1ns/1ps
`default_nettype none
module pcrc_clk_switch
    import pcrc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // synchronised oscillator levels and start-up flags
    input wire logic [3:0] osc_lvl,
    input wire logic [3:0] osc_ready,
    // requested setting
    input wire logic [1:0] req_src,
    input wire logic [3:0] req_div,
    // result
    output logic sys_clk,
    output logic pending,
    output logic [1:0] cur_src,
    output logic [3:0] cur_div
);
    typedef enum logic [1:0] {SW_RUN, SW_OLD, SW_NEW} pcrc_sw_type;
    pcrc_sw_type state;
    logic [3:0] lvl_q;
    logic [15:0] div_cnt;
    logic [1:0] edge_cnt;
    logic gate;
    logic old_rise;
    logic new_rise;
    logic divided;

    assign old_rise = osc_lvl[cur_src] & ~lvl_q[cur_src];
    assign new_rise = osc_lvl[req_src] & ~lvl_q[req_src];
    assign divided = (cur_div == 4'h0) ? osc_lvl[cur_src] : div_cnt[cur_div - 4'h1];
    assign pending = (state != SW_RUN);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= 4'h0;
        end else begin
            lvl_q <= osc_lvl;
        end
    end

    // prescaler counts rising edges of the current source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 16'h0000;
        end else if (state == SW_NEW) begin
            div_cnt <= 16'h0000;
        end else if (old_rise) begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    // old clock gated off after two of its edges, new one enabled after two of its own
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SW_RUN;
            edge_cnt <= 2'h0;
            gate <= 1'b1;
            cur_src <= PCRC_SRC_RC;
            cur_div <= PCRC_RST_DIV;
        end else begin
            case (state)
                SW_RUN: begin
                    edge_cnt <= 2'h0;
                    if (req_src != cur_src || req_div != cur_div) begin
                        state <= SW_OLD;
                    end
                end
                SW_OLD: begin
                    if (edge_cnt >= 2'(PCRC_SWITCH_EDGES) && !divided) begin
                        gate <= 1'b0;
                        edge_cnt <= 2'h0;
                        state <= SW_NEW;
                    end else if (old_rise && edge_cnt < 2'(PCRC_SWITCH_EDGES)) begin
                        edge_cnt <= edge_cnt + 2'h1;
                    end
                end
                SW_NEW: begin
                    // new edges only counted once the oscillator has started
                    if (osc_ready[req_src] && new_rise) begin
                        if (edge_cnt == 2'(PCRC_SWITCH_EDGES - 1)) begin
                            cur_src <= req_src;
                            cur_div <= req_div;
                            gate <= 1'b1;
                            state <= SW_RUN;
                        end else begin
                            edge_cnt <= edge_cnt + 2'h1;
                        end
                    end
                end
                default: begin
                    state <= SW_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_clk <= 1'b0;
        end else begin
            sys_clk <= gate & divided;
        end
    end
endmodule
`default_nettype wire

/* File: pcrc_pkg.sv */
// package: register map, field positions, reset values and timing of the power clock reset block
package pcrc_pkg;
    // register byte offsets
    localparam logic [7:0] PCRC_OFS_POWER = 8'h00;
    localparam logic [7:0] PCRC_OFS_CLKSEL = 8'h04;
    localparam logic [7:0] PCRC_OFS_CLOCK_SWITCH_STATUS_REG = 8'h08;
    localparam logic [7:0] PCRC_OFS_RETAIN = 8'h0C;
    localparam logic [7:0] PCRC_OFS_MONITOR = 8'h10;
    localparam logic [7:0] PCRC_OFS_FLLCTRL = 8'h14;
    localparam logic [7:0] PCRC_OFS_FLLTARGET = 8'h18;
    localparam logic [7:0] PCRC_OFS_FLLSTAT = 8'h1C;
    localparam logic [7:0] PCRC_OFS_IRQEN = 8'h20;
    localparam logic [7:0] PCRC_OFS_IRQPRIO = 8'h24;
    localparam logic [7:0] PCRC_OFS_SCRATCH = 8'h28;
    localparam logic [7:0] PCRC_OFS_IRQVEC = 8'h2C;
    // power control fields
    localparam int PCRC_POS_SOFTRST = 2;
    localparam int PCRC_POS_CAUSE = 4;
    localparam logic [1:0] PCRC_MODE_RUN = 2'h0;
    localparam logic [1:0] PCRC_MODE_STANDBY = 2'h1;
    localparam logic [1:0] PCRC_MODE_SLEEP = 2'h2;
    localparam logic [1:0] PCRC_MODE_DEEP = 2'h3;
    // reset cause one-hot codes
    localparam logic [3:0] PCRC_CAUSE_POR = 4'h1;
    localparam logic [3:0] PCRC_CAUSE_WAKE = 4'h2;
    localparam logic [3:0] PCRC_CAUSE_WDOG = 4'h4;
    localparam logic [3:0] PCRC_CAUSE_SOFT = 4'h8;
    // clock select fields: source in [1:0], prescale exponent in [5:2]
    localparam int PCRC_POS_DIV = 2;
    localparam logic [1:0] PCRC_SRC_RFXTAL = 2'h0;
    localparam logic [1:0] PCRC_SRC_LFXTAL = 2'h1;
    localparam logic [1:0] PCRC_SRC_RC = 2'h2;
    localparam logic [1:0] PCRC_SRC_LPOSC = 2'h3;
    localparam logic [3:0] PCRC_RST_DIV = 4'h1;
    // fll control fields
    localparam int PCRC_POS_FLL_EN = 0;
    localparam int PCRC_POS_FLL_REF = 1;
    localparam int PCRC_POS_FLL_SLAVE = 2;
    localparam logic [7:0] PCRC_RST_TRIM = 8'h80;
    localparam logic [15:0] PCRC_RST_MONITOR = 16'h0400;
    localparam logic [15:0] PCRC_RST_TARGET = 16'h0000;
    // interrupt layout
    localparam int PCRC_NIRQ = 22;
    localparam int PCRC_IRQ_PORT = 0;
    localparam int PCRC_IRQ_SYSCTL = 1;
    localparam logic [15:0] PCRC_VEC_BASE = 16'h0003;
    localparam logic [15:0] PCRC_RESET_VECTOR = 16'h0000;
    // timing
    localparam int PCRC_CLK_MHZ = 40;
    localparam int PCRC_CPU_RST_NS = 200;
    localparam int PCRC_CPU_RST_CYC = (PCRC_CPU_RST_NS * PCRC_CLK_MHZ + 999) / 1000;
    localparam int PCRC_SWITCH_EDGES = 2;
    localparam int PCRC_FLL_WINDOW = 16;
    localparam int PCRC_REF_TIMEOUT = 256;
endpackage

/* File: pcrc_top.sv */
// power mode, clock select, clock monitor, fll, reset and interrupt vector controller
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcrc_top
    import pcrc_pkg::*;
#(
    parameter int NIRQ = PCRC_NIRQ,
    parameter int CPU_RST_CYC = PCRC_CPU_RST_CYC,
    parameter int FLL_WINDOW = PCRC_FLL_WINDOW,
    parameter int REF_TIMEOUT = PCRC_REF_TIMEOUT
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // oscillators: rf xtal, lf xtal, rc, low-power
    input wire logic [3:0] osc_clk,
    input wire logic [3:0] osc_started,
    // pins and events
    input wire logic deep_wake_pin,
    input wire logic watchdog_expire,
    input wire logic [NIRQ-1:0] irq_lines,
    // processor side
    output logic cpu_rst_n,
    output logic cpu_halt,
    output logic [15:0] cpu_reset_vector,
    output logic irq_request,
    output logic [15:0] irq_vector,
    // power domains
    output logic periph_clk_en,
    output logic periph_pwr_en,
    output logic iram_pwr_en,
    output logic [1:0] xram_pwr_en,
    output logic radio_pwr_en,
    // clocks
    output logic sys_clk,
    output logic [7:0] osc_trim,
    output logic fll_locked
);
    typedef enum logic [1:0] {PM_RUN, PM_STANDBY, PM_SLEEP, PM_DEEP} pcrc_pm_type;
    logic rst_q1;
    logic rst_n;
    logic [5:0] pin_q1;
    logic [5:0] pin_q2;
    logic [3:0] osc_q1;
    logic [3:0] osc_lvl;
    logic [3:0] rdy_q1;
    logic [3:0] osc_rdy;
    pcrc_pm_type pm;
    logic [1:0] mode_field;
    logic [3:0] cause;
    logic [1:0] retain;
    logic [1:0] clk_src;
    logic [3:0] clk_div;
    logic [15:0] monitor_ivl;
    logic [15:0] monitor_cnt;
    logic [2:0] fll_ctrl;
    logic [15:0] fll_target;
    logic [NIRQ-1:0] irq_en;
    logic [NIRQ-1:0] irq_prio;
    logic [31:0] scratch;
    logic [7:0] rst_cnt;
    logic ack;
    logic wr_en;
    logic rd_en;
    logic sys_q;
    logic sw_pending;
    logic [1:0] cur_src;
    logic [3:0] cur_div;
    logic wake_pin_n;
    logic [NIRQ-1:0] irq_act;
    logic wake_sleep;
    logic wake_deep;
    logic soft_req;
    logic reset_evt;
    logic [3:0] next_cause;
    logic ref_lvl;
    logic ref_q;
    logic slv_lvl;
    logic slv_q;
    logic [15:0] ref_edges;
    logic [15:0] slv_edges;
    logic [15:0] ref_idle;
    logic ref_running;
    logic [31:0] rd_mux;

    // reset release through two flip-flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // two-flop synchronisers for oscillator levels, start flags and the wake pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_q1 <= 4'h0;
            osc_lvl <= 4'h0;
            rdy_q1 <= 4'h0;
            osc_rdy <= 4'h0;
            pin_q1 <= 6'h3F;
            pin_q2 <= 6'h3F;
        end else begin
            osc_q1 <= osc_clk;
            osc_lvl <= osc_q1;
            rdy_q1 <= osc_started;
            osc_rdy <= rdy_q1;
            pin_q1 <= {5'h1F, deep_wake_pin};
            pin_q2 <= pin_q1;
        end
    end
    assign wake_pin_n = pin_q2[0];

    // avalon: one wait cycle then the answer
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_en = avs_write & ~ack;
    assign rd_en = avs_read & ~ack;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    always_comb begin
        rd_mux = 32'h00000000;
        case (avs_address)
            PCRC_OFS_POWER: rd_mux = {24'h000000, cause, 2'h0, mode_field};
            PCRC_OFS_CLKSEL: rd_mux = {26'h0, clk_div, clk_src};
            PCRC_OFS_CLOCK_SWITCH_STATUS_REG: rd_mux = {25'h0, cur_div, cur_src, sw_pending};
            PCRC_OFS_RETAIN: rd_mux = {30'h0, retain};
            PCRC_OFS_MONITOR: rd_mux = {16'h0000, monitor_ivl};
            PCRC_OFS_FLLCTRL: rd_mux = {29'h0, fll_ctrl};
            PCRC_OFS_FLLTARGET: rd_mux = {16'h0000, fll_target};
            PCRC_OFS_FLLSTAT: rd_mux = {23'h0, fll_locked, osc_trim};
            PCRC_OFS_IRQEN: rd_mux = 32'(irq_en);
            PCRC_OFS_IRQPRIO: rd_mux = 32'(irq_prio);
            PCRC_OFS_SCRATCH: rd_mux = scratch;
            PCRC_OFS_IRQVEC: rd_mux = {15'h0, irq_request, irq_vector};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (rd_en) begin
            avs_readdata <= rd_mux;
        end
    end

    // wake and reset events
    assign irq_act = irq_lines & irq_en;
    assign wake_sleep = irq_act[PCRC_IRQ_PORT] | irq_act[PCRC_IRQ_SYSCTL];
    assign wake_deep = ~wake_pin_n;
    assign soft_req = wr_en && avs_address == PCRC_OFS_POWER
        && avs_writedata[PCRC_POS_SOFTRST];
    always_comb begin
        next_cause = cause;
        reset_evt = 1'b0;
        if (soft_req) begin
            next_cause = PCRC_CAUSE_SOFT;
            reset_evt = 1'b1;
        end else if (watchdog_expire) begin
            next_cause = PCRC_CAUSE_WDOG;
            reset_evt = 1'b1;
        end else if ((pm == PM_SLEEP && wake_sleep) || (pm == PM_DEEP && wake_deep)) begin
            next_cause = PCRC_CAUSE_WAKE;
            reset_evt = 1'b1;
        end
    end

    // power mode state follows the mode field; wake clears it to running
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pm <= PM_RUN;
            mode_field <= PCRC_MODE_RUN;
            cause <= PCRC_CAUSE_POR;
        end else begin
            cause <= next_cause;
            case (pm)
                PM_RUN: begin
                    if (wr_en && avs_address == PCRC_OFS_POWER && !soft_req) begin
                        mode_field <= avs_writedata[1:0];
                        case (avs_writedata[1:0])
                            PCRC_MODE_STANDBY: pm <= PM_STANDBY;
                            PCRC_MODE_SLEEP: pm <= PM_SLEEP;
                            PCRC_MODE_DEEP: pm <= PM_DEEP;
                            default: pm <= PM_RUN;
                        endcase
                    end
                end
                PM_STANDBY: begin
                    if (|irq_act || watchdog_expire || soft_req) begin
                        pm <= PM_RUN;
                        mode_field <= PCRC_MODE_RUN;
                    end
                end
                PM_SLEEP: begin
                    if (wake_sleep || watchdog_expire) begin
                        pm <= PM_RUN;
                        mode_field <= PCRC_MODE_RUN;
                    end
                end
                PM_DEEP: begin
                    if (wake_deep) begin
                        pm <= PM_RUN;
                        mode_field <= PCRC_MODE_RUN;
                    end
                end
                default: begin
                    pm <= PM_RUN;
                end
            endcase
        end
    end

    // processor reset pulse; fetch restarts at the reset vector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt <= 8'(CPU_RST_CYC);
        end else if (reset_evt) begin
            rst_cnt <= 8'(CPU_RST_CYC);
        end else if (rst_cnt != 8'h00) begin
            rst_cnt <= rst_cnt - 8'h01;
        end
    end
    assign cpu_rst_n = (rst_cnt == 8'h00) && (pm != PM_SLEEP) && (pm != PM_DEEP);
    assign cpu_reset_vector = PCRC_RESET_VECTOR;

    // power domain controls
    assign cpu_halt = (pm != PM_RUN);
    assign periph_clk_en = (pm == PM_RUN) || (pm == PM_STANDBY);
    assign periph_pwr_en = (pm == PM_RUN) || (pm == PM_STANDBY);
    assign iram_pwr_en = (pm != PM_DEEP);
    assign radio_pwr_en = (pm != PM_DEEP);
    assign xram_pwr_en = (pm == PM_DEEP) ? 2'h0 : (pm == PM_SLEEP) ? retain : 2'h3;

    // clock select; monitor restore beats a write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_src <= PCRC_SRC_RC;
            clk_div <= PCRC_RST_DIV;
        end else if (monitor_cnt >= monitor_ivl && monitor_ivl != 16'h0000) begin
            clk_src <= PCRC_SRC_RC;
            clk_div <= PCRC_RST_DIV;
        end else if (wr_en && avs_address == PCRC_OFS_CLKSEL) begin
            clk_src <= avs_writedata[1:0];
            clk_div <= avs_writedata[PCRC_POS_DIV +: 4];
        end
    end

    // other software registers, never blocked by the monitor
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            retain <= 2'h3;
            monitor_ivl <= PCRC_RST_MONITOR;
            fll_ctrl <= 3'h0;
            fll_target <= PCRC_RST_TARGET;
            irq_en <= '0;
            irq_prio <= '0;
        end else if (wr_en) begin
            case (avs_address)
                PCRC_OFS_RETAIN: retain <= avs_writedata[1:0];
                PCRC_OFS_MONITOR: monitor_ivl <= avs_writedata[15:0];
                PCRC_OFS_FLLCTRL: fll_ctrl <= avs_writedata[2:0];
                PCRC_OFS_FLLTARGET: fll_target <= avs_writedata[15:0];
                PCRC_OFS_IRQEN: irq_en <= avs_writedata[NIRQ-1:0];
                PCRC_OFS_IRQPRIO: irq_prio <= avs_writedata[NIRQ-1:0];
                default: begin
                end
            endcase
        end
    end

    // scratch survives every power mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scratch <= 32'h00000000;
        end else if (wr_en && avs_address == PCRC_OFS_SCRATCH) begin
            scratch <= avs_writedata;
        end
    end

    pcrc_clk_switch u_switch (
        .clk(clk),
        .rst_n(rst_n),
        .osc_lvl(osc_lvl),
        .osc_ready(osc_rdy | 4'hC),
        .req_src(clk_src),
        .req_div(clk_div),
        .sys_clk(sys_clk),
        .pending(sw_pending),
        .cur_src(cur_src),
        .cur_div(cur_div)
    );

    // clock monitor counts cycles since the last system clock transition
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_q <= 1'b0;
            monitor_cnt <= 16'h0000;
        end else begin
            sys_q <= sys_clk;
            if (sys_q != sys_clk || sw_pending || monitor_cnt >= monitor_ivl) begin
                monitor_cnt <= 16'h0000;
            end else begin
                monitor_cnt <= monitor_cnt + 16'h0001;
            end
        end
    end

    // frequency locked loop
    assign ref_lvl = fll_ctrl[PCRC_POS_FLL_REF] ? osc_lvl[1] : osc_lvl[0];
    assign slv_lvl = fll_ctrl[PCRC_POS_FLL_SLAVE] ? osc_lvl[3] : osc_lvl[2];
    assign ref_running = (ref_idle < 16'(REF_TIMEOUT));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_q <= 1'b0;
            slv_q <= 1'b0;
            ref_idle <= 16'(REF_TIMEOUT);
        end else begin
            ref_q <= ref_lvl;
            slv_q <= slv_lvl;
            if (ref_lvl && !ref_q) begin
                ref_idle <= 16'h0000;
            end else if (ref_running) begin
                ref_idle <= ref_idle + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_edges <= 16'h0000;
            slv_edges <= 16'h0000;
            osc_trim <= PCRC_RST_TRIM;
            fll_locked <= 1'b0;
        end else if (!fll_ctrl[PCRC_POS_FLL_EN] || !ref_running) begin
            ref_edges <= 16'h0000;
            slv_edges <= 16'h0000;
            fll_locked <= 1'b0;
        end else if (ref_lvl && !ref_q && ref_edges == 16'(FLL_WINDOW - 1)) begin
            ref_edges <= 16'h0000;
            slv_edges <= 16'h0000;
            fll_locked <= (slv_edges == fll_target);
            if (slv_edges < fll_target && osc_trim != 8'hFF) begin
                osc_trim <= osc_trim + 8'h01;
            end else if (slv_edges > fll_target && osc_trim != 8'h00) begin
                osc_trim <= osc_trim - 8'h01;
            end
        end else begin
            if (ref_lvl && !ref_q) begin
                ref_edges <= ref_edges + 16'h0001;
            end
            if (slv_lvl && !slv_q) begin
                slv_edges <= slv_edges + 16'h0001;
            end
        end
    end

    // interrupt vector: high priority first, then lowest index
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_request <= 1'b0;
            irq_vector <= PCRC_VEC_BASE;
        end else begin
            irq_request <= |irq_act;
            for (int i = NIRQ - 1; i >= 0; i--) begin
                if (irq_act[i] && (irq_prio[i] || !(|(irq_act & irq_prio)))) begin
                    irq_vector <= PCRC_VEC_BASE + 16'(i * 8);
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: pcrc_top_properties.sv */
// checker: concurrent properties on the power clock reset controller ports
`timescale 1ns/1ps
`default_nettype none
module pcrc_top_properties (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // wake pin
    input wire logic deep_wake_pin,
    // processor side
    input wire logic cpu_rst_n,
    input wire logic cpu_halt,
    input wire logic [15:0] cpu_reset_vector,
    input wire logic irq_request,
    input wire logic [15:0] irq_vector,
    // power domains
    input wire logic periph_clk_en,
    input wire logic periph_pwr_en,
    input wire logic iram_pwr_en,
    input wire logic [1:0] xram_pwr_en,
    input wire logic radio_pwr_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_vec; cpu_reset_vector == 16'h0000; endproperty
    a_vec: assert property (p_vec) else $error("reset vector not zero");
    property p_clk; periph_clk_en == periph_pwr_en; endproperty
    a_clk: assert property (p_clk) else $error("peripheral clock and power differ");
    property p_deep;
        !iram_pwr_en |-> xram_pwr_en == 2'h0 && !radio_pwr_en && !periph_pwr_en;
    endproperty
    a_deep: assert property (p_deep) else $error("domain on in deepest mode");
    property p_xram; periph_pwr_en |-> xram_pwr_en == 2'h3; endproperty
    a_xram: assert property (p_xram) else $error("xram off while running");
    property p_halt; !periph_pwr_en |-> cpu_halt; endproperty
    a_halt: assert property (p_halt) else $error("processor runs with peripherals off");
    property p_irq; irq_request |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h00AB; endproperty
    a_irq: assert property (p_irq) else $error("interrupt vector off grid");
    property p_wake; deep_wake_pin[*4] ##0 !iram_pwr_en |=> !iram_pwr_en; endproperty
    a_wake: assert property (p_wake) else $error("deepest mode left without wake pin");
    property p_rlen; $fell(cpu_rst_n) |-> !cpu_rst_n[*8]; endproperty
    a_rlen: assert property (p_rlen) else $error("processor reset too short");
    property p_rend; !cpu_rst_n && !cpu_halt |-> ##[0:12] cpu_rst_n; endproperty
    a_rend: assert property (p_rend) else $error("processor reset not released");
    c_deep: cover property (!iram_pwr_en);
    c_sleep: cover property (!periph_pwr_en && iram_pwr_en);
    c_irq: cover property (irq_request);
endmodule
bind pcrc_top pcrc_top_properties u_props (.*);
`default_nettype wire

/* File: testbench.sv */
// testbench: register, power mode, reset and interrupt checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, nrst, avs_read, avs_write, avs_waitrequest, deep_wake_pin, watchdog_expire;
    logic cpu_halt, periph_pwr_en, iram_pwr_en, cpu_rst_n, sys_clk;
    logic [1:0] xram_pwr_en;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, d;
    logic [31:0] seed = 32'h52F6;
    logic [3:0] osc_clk, osc_started;
    logic [21:0] irq_lines;
    logic [31:0] m[$];
    int n_mismatch, compares, i, k;
    pcrc_top uut (.*, .cpu_reset_vector(), .irq_request(), .irq_vector(), .periph_clk_en(),
        .radio_pwr_en(), .osc_trim(), .fll_locked());
    always #12.5 clk = ~clk;
    always #7 osc_clk = osc_clk + 4'h1;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string n, input logic [31:0] e, s);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] dd);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= dd;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task wait_sw();
        k = 0;
        do begin
            bus(1'b0, 8'h08, 32'h0);
            k++;
        end while (q[0] !== 1'b0 && k < 100);
    endtask
    task end_sim();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata, watchdog_expire, irq_lines} = '0;
        {clk, nrst, osc_clk, osc_started} = '0;
        deep_wake_pin = 1'b1;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h04, 32'h6);
        rd(8'h0C, 32'h3);
        rd(8'h00, 32'h10);
        rd(8'h3C, 32'h0);
        k = 0;
        repeat (8) begin
            @(posedge clk);
            k += sys_clk;
        end
        chk("sys_clk", 32'h1, {31'h0, k > 0 && k < 8});
        for (i = 0; i < 4; i++) begin
            d = rnd();
            m.push_back(d);
            bus(1'b1, 8'h28, d);
            rd(8'h28, m.pop_front());
        end
        bus(1'b1, 8'h20, 32'h3FFFFF);
        for (i = 0; i < 22; i++) begin
            irq_lines <= 22'h1 << i;
            repeat (3) @(posedge clk);
            rd(8'h2C, 32'h10000 | (32'h3 + 32'h8 * i));
        end
        bus(1'b1, 8'h24, 32'h20);
        irq_lines <= 22'h21;
        repeat (3) @(posedge clk);
        rd(8'h2C, 32'h1002B);
        irq_lines <= '0;
        bus(1'b1, 8'h04, 32'h3);
        bus(1'b0, 8'h08, 32'h0);
        chk("pending", 32'h1, {31'h0, q[0]});
        wait_sw();
        chk("clock_switch_status_reg", 32'h6, q);
        bus(1'b1, 8'h04, 32'h0);
        repeat (40) @(posedge clk);
        bus(1'b0, 8'h08, 32'h0);
        chk("start_wait", 32'h1, {31'h0, q[0]});
        osc_started <= 4'hF;
        wait_sw();
        chk("clock_switch_status_reg", 32'h0, q);
        bus(1'b1, 8'h10, 32'h1);
        repeat (20) @(posedge clk);
        rd(8'h04, 32'h6);
        bus(1'b1, 8'h10, 32'h400);
        bus(1'b1, 8'h00, 32'h4);
        chk("cpu_rst_n", 32'h0, {31'h0, cpu_rst_n});
        repeat (12) @(posedge clk);
        chk("cpu_rst_n", 32'h1, {31'h0, cpu_rst_n});
        rd(8'h00, 32'h80);
        watchdog_expire <= 1'b1;
        @(posedge clk);
        watchdog_expire <= 1'b0;
        repeat (12) @(posedge clk);
        rd(8'h00, 32'h40);
        bus(1'b1, 8'h00, 32'h1);
        chk("halt", 32'h1, {31'h0, cpu_halt});
        irq_lines <= 22'h4;
        repeat (3) @(posedge clk);
        chk("halt", 32'h0, {31'h0, cpu_halt});
        bus(1'b1, 8'h0C, 32'h1);
        bus(1'b1, 8'h00, 32'h2);
        repeat (4) @(posedge clk);
        chk("periph", 32'h0, {31'h0, periph_pwr_en});
        chk("xram", 32'h1, {30'h0, xram_pwr_en});
        irq_lines <= 22'h2;
        repeat (16) @(posedge clk);
        irq_lines <= '0;
        rd(8'h00, 32'h20);
        bus(1'b1, 8'h00, 32'h3);
        irq_lines <= 22'h3;
        repeat (6) @(posedge clk);
        chk("iram", 32'h0, {31'h0, iram_pwr_en});
        irq_lines <= '0;
        deep_wake_pin <= 1'b0;
        repeat (6) @(posedge clk);
        deep_wake_pin <= 1'b1;
        repeat (12) @(posedge clk);
        rd(8'h00, 32'h20);
        bus(1'b1, 8'h14, 32'h1);
        repeat (300) @(posedge clk);
        bus(1'b0, 8'h1C, 32'h0);
        chk("fll", 32'h1, {31'h0, q[7:0] < 8'h80 && !q[8]});
        end_sim();
    end
endmodule
`default_nettype wire
